// [verilog/seq_pkg.sv]
// constants and types shared by the step sequencer and its step memory
// assumes a 100 MHz system clock
package seq_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int MAX_STEPS = 1000;
  localparam int MIN_STEPS = 3;
  localparam int STEP_AW = 10;
  localparam int VALUE_W = 24;
  localparam int LOOP_W = 14;
  localparam int MAX_LOOPS = 9999;
  localparam int MEMO_CHARS = 12;
  localparam int MEMO_W = MEMO_CHARS * 8;

  // ------------------------------------------------------------
  // time base, in units of 0.025 ms
  // ------------------------------------------------------------
  localparam int CLK_HZ = 100000000;
  localparam int TB_UNIT_NS = 25000;
  localparam int TB_UNIT_CYC = TB_UNIT_NS / (1000000000 / CLK_HZ);
  localparam int TB_MIN_UNITS = 1;
  localparam int TB_MAX_UNITS = 24000;
  localparam int TB_W = 15;

  // ------------------------------------------------------------
  // modes and ranges
  // ------------------------------------------------------------
  localparam logic [1:0] MODE_CC = 2'h0;
  localparam logic [1:0] MODE_CR = 2'h1;
  localparam logic [1:0] MODE_CV = 2'h2;
  localparam logic [1:0] MODE_CP = 2'h3;

  typedef enum logic [2:0] {
    low_current_low_voltage_range,
    high_current_low_voltage_range,
    low_current_high_voltage_range,
    high_current_high_voltage_range,
    low_conductance_high_voltage_range,
    high_conductance_low_voltage_range
  } range_t;

  localparam logic [2:0] RANGE_RESET = 3'h0;
  localparam logic [VALUE_W-1:0] VALUE_RESET = 24'h000000;

endpackage : seq_pkg

// [verilog/step_mem_if.sv]
// carries step memory write and read traffic between sequencer and store
// assumes a single clock shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface step_mem_if #(parameter int AW = 10, parameter int DW = 25);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : step_mem_if
`default_nettype wire

// [verilog/step_mem.sv]
// step store: one word per step, value plus trigger flag
// assumes reads are registered, one cycle latency
`timescale 1ns/1ns
`default_nettype none
module step_mem
  import seq_pkg::*;
#(
  parameter int DEPTH = MAX_STEPS
)(
  input wire logic clk_in,          // system clock
  input wire logic ce_in,           // clock enable
  step_mem_if.mem bus               // access port
);
  logic [$bits(bus.wr_data)-1:0] store [DEPTH];
  always_ff @(posedge clk_in)
  begin
    if (ce_in)
    begin
      if (bus.wr_en)
        store[bus.wr_addr] <= bus.wr_data;
      bus.rd_data <= store[bus.rd_addr];
    end
  end
endmodule : step_mem
`default_nettype wire

// [verilog/load_step_sequencer.sv]
// step sequencer driving the load set value through programmed steps
// assumes synchronous inputs, operator settings held steady while running
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - seq mode and load on starts run
// - pause halts at step, continue resumes
// - load on with no steps flags empty
// - last step of last loop signals complete
// - sequence, step and, for finite loop counts, loop shown as status
// - mode indicator on, distinct when load on
// - every step uses one shared time base
// - time base 0.025 ms to 600 ms
// - store holds up to 1000 steps
// - loops 1 to 9999 or infinite
// - only constant current or resistance allowed
// - values change abruptly, no ramp
// - end hold applies programmed final value
// - last step per loop 1 to 1000
// - mode range loops time base shared
// - range picks one of six combinations
// - twelve character memo stored, no effect
// - at least three steps needed to run
// - trigger pulse at start of flagged step
module load_step_sequencer
  import seq_pkg::*;
#(
  parameter int TB_UNIT = TB_UNIT_CYC,
  parameter int DEPTH = MAX_STEPS
)(
  input wire logic CLK_IN,                      // 100 MHz clock
  input wire logic NRST_IN,                     // sync reset, active low
  input wire logic CE_IN,                       // clock enable
  input wire logic SEQ_ENABLE_IN,               // sequence mode on
  input wire logic LOAD_ON_IN,                  // load switched on
  input wire logic PAUSE_IN,                    // pause pulse
  input wire logic CONTINUE_IN,                 // continue pulse
  input wire logic [3:0] SEQ_NUM_IN,            // selected sequence number
  input wire logic SET_WR_IN,                   // latch settings pulse
  input wire logic [1:0] MODE_IN,               // operating mode
  input wire logic [2:0] RANGE_IN,              // range combination
  input wire logic [LOOP_W-1:0] LOOP_COUNT_IN,  // loops, 0 = infinite
  input wire logic END_HOLD_IN,                 // hold final value
  input wire logic [VALUE_W-1:0] FINAL_VALUE_IN, // final set value
  input wire logic [STEP_AW:0] LAST_STEP_IN,    // last step per loop
  input wire logic [TB_W-1:0] TIME_BASE_IN,     // step time, 0.025 ms units
  input wire logic [MEMO_W-1:0] MEMO_IN,        // user note
  input wire logic [STEP_AW:0] NUM_STEPS_IN,    // defined step count
  input wire logic STEP_WR_IN,                  // step write pulse
  input wire logic [STEP_AW-1:0] STEP_ADDR_IN,  // step index, 0 based
  input wire logic [VALUE_W-1:0] STEP_VALUE_IN, // step set value
  input wire logic STEP_TRIG_IN,                // step trigger flag
  output logic [VALUE_W-1:0] SET_VALUE_OUT,     // value to load stage
  output logic SET_VALID_OUT,                   // set value applied
  output logic step_trigger_output,             // trigger pulse
  output logic SEQ_IND_OUT,                     // sequence_mode_indicator
  output logic SEQ_IND_ACTIVE_OUT,              // indicator distinct state
  output logic RUNNING_OUT,                     // sequence running
  output logic PAUSED_OUT,                      // sequence paused
  output logic EMPTY_OUT,                       // empty sequence flag
  output logic COMPLETE_OUT,                    // sequence complete flag
  output logic SETTING_ERR_OUT,                 // settings refused
  output logic [3:0] SEQ_NUM_OUT,               // active sequence
  output logic [STEP_AW:0] STEP_OUT,            // active step, 1 based
  output logic [LOOP_W-1:0] LOOP_OUT,           // current loop, 1 based; held at 1 for infinite loops
  output logic [1:0] MODE_OUT,                  // held mode
  output logic [2:0] RANGE_OUT,                 // held range
  output logic [MEMO_W-1:0] MEMO_OUT            // held memo
);

  // ------------------------------------------------------------
  // shared settings
  // ------------------------------------------------------------
  logic [LOOP_W-1:0] loops_ff;
  logic end_hold_ff;
  logic [VALUE_W-1:0] final_ff;
  logic [STEP_AW:0] last_step_ff;
  logic [TB_W-1:0] tb_ff;

  function automatic logic settings_ok(input logic [1:0] m, input logic [2:0] r,
                                       input logic [LOOP_W-1:0] l,
                                       input logic [STEP_AW:0] ls,
                                       input logic [TB_W-1:0] t);
    settings_ok = (m == MODE_CC || m == MODE_CR)
      && (r <= 3'(high_conductance_low_voltage_range))
      && (l <= LOOP_W'(MAX_LOOPS))
      && (ls >= (STEP_AW+1)'(1)) && (ls <= (STEP_AW+1)'(DEPTH))
      && (t >= TB_W'(TB_MIN_UNITS)) && (t <= TB_W'(TB_MAX_UNITS));
  endfunction : settings_ok

  typedef enum logic [2:0] {IDLE, LOAD, RUN, PAUSED, DONE} state_t;
  state_t state_ff;
  logic active;
  assign active = SEQ_ENABLE_IN && LOAD_ON_IN;

  // one setting set for all steps; refused while running
  always_ff @(posedge CLK_IN)
  begin
    if (!NRST_IN)
    begin
      MODE_OUT <= MODE_CC;
      RANGE_OUT <= RANGE_RESET;
      loops_ff <= LOOP_W'(1);
      end_hold_ff <= 1'b0;
      final_ff <= VALUE_RESET;
      last_step_ff <= (STEP_AW+1)'(1);
      tb_ff <= TB_W'(TB_MIN_UNITS);
      MEMO_OUT <= '0;
      SETTING_ERR_OUT <= 1'b0;
    end
    else if (CE_IN && SET_WR_IN)
    begin
      if (state_ff == IDLE && settings_ok(MODE_IN, RANGE_IN, LOOP_COUNT_IN,
                                          LAST_STEP_IN, TIME_BASE_IN))
      begin
        MODE_OUT <= MODE_IN;
        RANGE_OUT <= RANGE_IN;
        loops_ff <= LOOP_COUNT_IN;
        end_hold_ff <= END_HOLD_IN;
        final_ff <= FINAL_VALUE_IN;
        last_step_ff <= LAST_STEP_IN;
        tb_ff <= TIME_BASE_IN;
        MEMO_OUT <= MEMO_IN;
        SETTING_ERR_OUT <= 1'b0;
      end
      else
        SETTING_ERR_OUT <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // step store
  // ------------------------------------------------------------
  step_mem_if #(.AW(STEP_AW), .DW(VALUE_W + 1)) mbus ();
  logic [STEP_AW-1:0] idx_ff;
  assign mbus.wr_en = STEP_WR_IN && (32'(STEP_ADDR_IN) < DEPTH);
  assign mbus.wr_addr = STEP_ADDR_IN;
  assign mbus.wr_data = {STEP_TRIG_IN, STEP_VALUE_IN};
  assign mbus.rd_addr = idx_ff;

  step_mem #(.DEPTH(DEPTH)) step_mem_inst (
    .clk_in(CLK_IN),
    .ce_in(CE_IN),
    .bus(mbus)
  );

  // ------------------------------------------------------------
  // timing and sequencing
  // ------------------------------------------------------------
  logic [31:0] unit_cnt_ff;
  logic [TB_W-1:0] tb_cnt_ff;
  logic step_end;
  logic last_in_loop;
  logic last_loop;
  logic runnable;
  logic [STEP_AW:0] loop_end;
  logic counting;

  assign loop_end = (last_step_ff < NUM_STEPS_IN) ? last_step_ff : NUM_STEPS_IN;
  assign step_end = (unit_cnt_ff == 32'(TB_UNIT - 1)) && (tb_cnt_ff == tb_ff - TB_W'(1));
  assign last_in_loop = ({1'b0, idx_ff} == loop_end - (STEP_AW+1)'(1));
  assign last_loop = (loops_ff != '0) && (LOOP_OUT == loops_ff);
  assign runnable = NUM_STEPS_IN >= (STEP_AW+1)'(MIN_STEPS);
  // a pause caught on a step's last cycle keeps the timer at its end
  assign counting = (state_ff == LOAD) || (state_ff == RUN && !PAUSE_IN);

  // time base divider, identical for every step
  // the load cycle counts toward the step, so no per-step overhead
  always_ff @(posedge CLK_IN)
  begin
    if (!NRST_IN)
    begin
      unit_cnt_ff <= '0;
      tb_cnt_ff <= '0;
    end
    else if (CE_IN)
    begin
      if (state_ff == IDLE || state_ff == DONE)
      begin
        unit_cnt_ff <= '0;
        tb_cnt_ff <= '0;
      end
      else if (counting)
      begin
        if (unit_cnt_ff == 32'(TB_UNIT - 1))
        begin
          unit_cnt_ff <= '0;
          tb_cnt_ff <= step_end ? '0 : tb_cnt_ff + TB_W'(1);
        end
        else
          unit_cnt_ff <= unit_cnt_ff + 32'd1;
      end
    end
  end

  // run state and counters
  always_ff @(posedge CLK_IN)
  begin
    if (!NRST_IN)
    begin
      state_ff <= IDLE;
      idx_ff <= '0;
      LOOP_OUT <= LOOP_W'(1);
      EMPTY_OUT <= 1'b0;
      COMPLETE_OUT <= 1'b0;
    end
    else if (CE_IN)
    begin
      if (!active)
      begin
        state_ff <= IDLE;
        idx_ff <= '0;
        LOOP_OUT <= LOOP_W'(1);
        COMPLETE_OUT <= 1'b0;
        EMPTY_OUT <= 1'b0;
      end
      else
      begin
        unique case (state_ff)
          IDLE:
          begin
            if (!runnable)
              EMPTY_OUT <= 1'b1;
            else
            begin
              state_ff <= LOAD;
              EMPTY_OUT <= 1'b0;
            end
          end
          LOAD:
            state_ff <= RUN;
          RUN:
          begin
            if (PAUSE_IN)
              state_ff <= PAUSED;
            else if (step_end)
            begin
              if (!last_in_loop)
              begin
                idx_ff <= idx_ff + STEP_AW'(1);
                state_ff <= LOAD;
              end
              else if (last_loop)
              begin
                state_ff <= DONE;
                COMPLETE_OUT <= 1'b1;
              end
              else
              begin
                idx_ff <= '0;
                if (loops_ff != '0)
                  LOOP_OUT <= LOOP_OUT + LOOP_W'(1);
                state_ff <= LOAD;
              end
            end
          end
          PAUSED:
            if (CONTINUE_IN)
              state_ff <= RUN;
          DONE:
            state_ff <= DONE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // outputs to the load stage and status
  // ------------------------------------------------------------
  logic loaded_ff;
  always_ff @(posedge CLK_IN)
  begin
    if (!NRST_IN)
    begin
      SET_VALUE_OUT <= VALUE_RESET;
      SET_VALID_OUT <= 1'b0;
      step_trigger_output <= 1'b0;
      loaded_ff <= 1'b0;
    end
    else if (CE_IN)
    begin
      loaded_ff <= (state_ff == LOAD);
      step_trigger_output <= 1'b0;
      // switching off wins, even over a held final value
      if (!active)
      begin
        SET_VALUE_OUT <= VALUE_RESET;
        SET_VALID_OUT <= 1'b0;
      end
      else if (loaded_ff)
      begin
        SET_VALUE_OUT <= mbus.rd_data[VALUE_W-1:0];
        SET_VALID_OUT <= 1'b1;
        step_trigger_output <= mbus.rd_data[VALUE_W];
      end
      else if (state_ff == DONE)
      begin
        SET_VALUE_OUT <= end_hold_ff ? final_ff : VALUE_RESET;
        SET_VALID_OUT <= end_hold_ff;
      end
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!NRST_IN)
    begin
      SEQ_IND_OUT <= 1'b0;
      SEQ_IND_ACTIVE_OUT <= 1'b0;
      RUNNING_OUT <= 1'b0;
      PAUSED_OUT <= 1'b0;
      SEQ_NUM_OUT <= 4'h0;
      STEP_OUT <= '0;
    end
    else if (CE_IN)
    begin
      SEQ_IND_OUT <= SEQ_ENABLE_IN;
      SEQ_IND_ACTIVE_OUT <= active;
      RUNNING_OUT <= active && (state_ff == RUN || state_ff == LOAD);
      PAUSED_OUT <= active && (state_ff == PAUSED);
      SEQ_NUM_OUT <= SEQ_NUM_IN;
      STEP_OUT <= {1'b0, idx_ff} + (STEP_AW+1)'(1);
    end
  end

endmodule : load_step_sequencer
`default_nettype wire

// [testbench/load_step_sequencer_asserts.sv]
// port-level checks of the step sequencer
// assumes one clock domain, sync active-low reset
`timescale 1ns/1ns
`default_nettype none
module load_step_sequencer_asserts
  import seq_pkg::*;
(
  input wire logic CLK_IN, // clock
  input wire logic NRST_IN, // reset
  input wire logic SEQ_ENABLE_IN, // mode
  input wire logic LOAD_ON_IN, // load on
  input wire logic CONTINUE_IN, // resume
  input wire logic SET_WR_IN, // settings
  input wire logic [1:0] MODE_IN, // mode req
  input wire logic [STEP_AW:0] NUM_STEPS_IN, // steps
  input wire logic [VALUE_W-1:0] SET_VALUE_OUT, // value
  input wire logic SET_VALID_OUT, // applied
  input wire logic step_trigger_output, // trigger
  input wire logic SEQ_IND_OUT, // indicator
  input wire logic SEQ_IND_ACTIVE_OUT, // distinct
  input wire logic RUNNING_OUT, // running
  input wire logic PAUSED_OUT, // paused
  input wire logic EMPTY_OUT, // empty
  input wire logic SETTING_ERR_OUT // refused
);
  logic act;
  assign act = SEQ_ENABLE_IN && LOAD_ON_IN;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // ----------------------------------------
  // run control
  // ----------------------------------------
  sequence s_start;
    $rose(act) && NUM_STEPS_IN >= 11'h003 ##1 act [*3];
  endsequence
  sequence s_frozen;
    PAUSED_OUT && $stable(PAUSED_OUT) && act && !CONTINUE_IN && !$past(CONTINUE_IN);
  endsequence
  run_start_a: assert property (s_start |-> ##[0:2] SET_VALID_OUT)
    else $error("run did not start");
  empty_flag_a: assert property ($rose(act) && NUM_STEPS_IN < 11'h003 |=> EMPTY_OUT)
    else $error("empty flag missing");
  pause_hold_a: assert property (s_frozen |=> $stable(SET_VALUE_OUT))
    else $error("value moved while paused");
  stop_clear_a: assert property ($fell(act) |=> !SET_VALID_OUT && !RUNNING_OUT)
    else $error("run not stopped");
  trig_pulse_a: assert property (step_trigger_output |=> !step_trigger_output)
    else $error("trigger longer than one cycle");
  // ----------------------------------------
  // indicator and settings
  // ----------------------------------------
  ind_on_a: assert property (act |=> SEQ_IND_OUT && SEQ_IND_ACTIVE_OUT)
    else $error("indicator not active");
  ind_off_a: assert property (!SEQ_ENABLE_IN |=> !SEQ_IND_OUT)
    else $error("indicator without mode");
  mode_refuse_a: assert property (SET_WR_IN && MODE_IN[1] |=> SETTING_ERR_OUT)
    else $error("bad mode accepted");
endmodule : load_step_sequencer_asserts
`default_nettype wire

// [testbench/load_stage_model.sv]
// behavioural load stage: logs each change of the applied set value
// assumes values settle on the rising edge
`timescale 1ns/1ns
`default_nettype none
module load_stage_model
  import seq_pkg::*;
(
  input wire logic clk_in, // clock
  input wire logic [VALUE_W-1:0] value_in, // set value
  input wire logic valid_in, // applied
  input wire logic clear_in, // forget history
  output int n_changes_out, // changes seen
  output int gap_out, // first step length
  output logic [VALUE_W-1:0] hist_out [8] // values in order
);
  logic [VALUE_W-1:0] prev;
  int since;
  // a ramp would show up as extra logged values
  always @(posedge clk_in)
  begin
    since <= since + 1;
    if (clear_in)
    begin
      n_changes_out <= 0;
      prev <= '0;
    end
    else if (valid_in && value_in !== prev)
    begin
      prev <= value_in;
      since <= 1;
      if (n_changes_out < 8)
        hist_out[n_changes_out] <= value_in;
      if (n_changes_out == 1)
        gap_out <= since;
      n_changes_out <= n_changes_out + 1;
    end
  end
endmodule : load_stage_model
`default_nettype wire

// [testbench/load_step_sequencer_tb.sv]
// self-checking bench for the step sequencer
// assumes the checker and load stage model are compiled first
`timescale 1ns/1ns
`default_nettype none
module load_step_sequencer_tb;
  import seq_pkg::*;
  localparam int TBU = 2; // short time unit keeps the run brief
  logic clk = 0, nrst = 0, ce = 1, en = 0, on = 0, pse = 0, cnt = 0, swr = 0, hold = 0;
  logic stwr = 0, sttrig = 0, clr = 1, vld, trg, ind, inda, run, psd, emp, cmp, err;
  logic [3:0] sn = 4'h5, sno;
  logic [1:0] md = 2'h0, mdo;
  logic [2:0] rg = 3'h0, rgo;
  logic [13:0] lp = 14'h0001, lpo;
  logic [23:0] fin = 24'hABCDEF, sval = 24'h000000, vo;
  logic [10:0] ls = 11'h001, ns = 11'h000, sto;
  logic [14:0] tbv = 15'h0001;
  logic [95:0] memo = 96'h4D454D4F, mmo;
  logic [9:0] sadr = 10'h000;
  logic [23:0] hist [8];
  int nch, gap, ntrig, n_mismatch, compares;
  always #5 clk = ~clk;
  always @(posedge clk) if (trg === 1'b1) ntrig++;
  load_step_sequencer #(.TB_UNIT(TBU), .DEPTH(MAX_STEPS)) load_step_sequencer_inst (
    .CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce), .SEQ_ENABLE_IN(en), .LOAD_ON_IN(on),
    .PAUSE_IN(pse), .CONTINUE_IN(cnt), .SEQ_NUM_IN(sn), .SET_WR_IN(swr), .MODE_IN(md),
    .RANGE_IN(rg), .LOOP_COUNT_IN(lp), .END_HOLD_IN(hold), .FINAL_VALUE_IN(fin),
    .LAST_STEP_IN(ls), .TIME_BASE_IN(tbv), .MEMO_IN(memo), .NUM_STEPS_IN(ns),
    .STEP_WR_IN(stwr), .STEP_ADDR_IN(sadr), .STEP_VALUE_IN(sval), .STEP_TRIG_IN(sttrig),
    .SET_VALUE_OUT(vo), .SET_VALID_OUT(vld), .step_trigger_output(trg), .SEQ_IND_OUT(ind),
    .SEQ_IND_ACTIVE_OUT(inda), .RUNNING_OUT(run), .PAUSED_OUT(psd), .EMPTY_OUT(emp),
    .COMPLETE_OUT(cmp), .SETTING_ERR_OUT(err), .SEQ_NUM_OUT(sno), .STEP_OUT(sto),
    .LOOP_OUT(lpo), .MODE_OUT(mdo), .RANGE_OUT(rgo), .MEMO_OUT(mmo));
  load_stage_model load_stage_model_inst (.clk_in(clk), .value_in(vo), .valid_in(vld),
    .clear_in(clr), .n_changes_out(nch), .gap_out(gap), .hist_out(hist));
  task automatic chk(input string what, input logic [95:0] seen, input logic [95:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic setup(input logic [1:0] m, input logic [2:0] r, input logic [13:0] l,
                       input logic h, input logic [10:0] s, input logic [14:0] t);
    @(negedge clk);
    md = m; rg = r; lp = l; hold = h; ls = s; tbv = t; swr = 1; clr = 1;
    @(negedge clk);
    swr = 0; clr = 0; ntrig = 0;
    @(negedge clk);
  endtask : setup
  task automatic wait_nch(input int n);
    for (int i = 0; i < 300 && nch < n; i++) @(negedge clk);
  endtask : wait_nch
  task automatic stop_run;
    en = 0; on = 0;
    repeat (3) @(negedge clk);
  endtask : stop_run
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_settings;
    for (int r = 0; r < 6; r++)
    begin
      setup(MODE_CR, r[2:0], 14'h0001, 0, 11'h003, 15'h0001);
      chk("range", rgo, r);
      chk("err", err, 0);
    end
    chk("mode", mdo, MODE_CR);
    chk("memo", mmo, memo);
    setup(MODE_CV, 0, 14'h0001, 0, 11'h003, 15'h0001);
    chk("cv", err, 1);
    setup(MODE_CP, 0, 14'h0001, 0, 11'h003, 15'h0001);
    chk("cp", err, 1);
    setup(MODE_CC, 0, 14'h2710, 0, 11'h003, 15'h0001);
    chk("loops", err, 1);
    setup(MODE_CC, 0, 14'h0001, 0, 11'h3E9, 15'h0001);
    chk("last", err, 1);
    setup(MODE_CC, 0, 14'h0001, 0, 11'h003, 15'h5DC1);
    chk("tbase", err, 1);
    setup(MODE_CC, 0, 14'h270F, 0, 11'h3E8, 15'h5DC0);
    chk("max", err, 0);
  endtask : t_settings
  task automatic t_empty;
    ns = 11'h002;
    en = 1; on = 1;
    repeat (3) @(negedge clk);
    chk("empty", emp, 1);
    chk("ind", inda, 1);
    chk("ind mode", ind, 1);
    stop_run();
    chk("empty clr", emp, 0);
  endtask : t_empty
  task automatic t_run;
    logic [23:0] exp [7] = '{24'h000011, 24'h000022, 24'h000033, 24'h000011, 24'h000022,
                             24'h000033, 24'hABCDEF};
    setup(MODE_CC, 0, 14'h0002, 1, 11'h003, 15'h0002);
    en = 1; on = 1;
    for (int i = 0; i < 300 && cmp !== 1'b1; i++) @(negedge clk);
    repeat (2) @(negedge clk);
    chk("done", cmp, 1);
    chk("final", vo, fin);
    chk("loop", lpo, 2);
    chk("seq", sno, sn);
    chk("count", nch, 7);
    for (int i = 0; i < 7; i++) chk("hist", hist[i], exp[i]);
    chk("step len", gap, TBU * 2);
    chk("trig", ntrig, 2);
    stop_run();
  endtask : t_run
  task automatic t_pause;
    logic [23:0] held;
    setup(MODE_CR, 0, 14'h0000, 0, 11'h003, 15'h0002);
    en = 1; on = 1;
    wait_nch(2);
    pse = 1;
    @(negedge clk);
    pse = 0;
    repeat (3) @(negedge clk);
    held = vo;
    chk("paused", psd, 1);
    repeat (20) @(negedge clk);
    chk("frozen", vo, held);
    chk("step", sto, 2);
    cnt = 1;
    @(negedge clk);
    cnt = 0;
    wait_nch(5);
    chk("resumed", psd, 0);
    chk("inf loop", lpo, 1);
    held = vo;
    ce = 0;
    repeat (10) @(negedge clk);
    chk("ce freeze", vo, held);
    ce = 1;
    en = 0;
    repeat (3) @(negedge clk);
    chk("stopped", run, 0);
    chk("step rst", sto, 1);
    chk("valid", vld, 0);
    stop_run();
  endtask : t_pause
  task automatic t_no_hold;
    setup(MODE_CC, 0, 14'h0001, 0, 11'h003, 15'h0001);
    en = 1; on = 1;
    for (int i = 0; i < 300 && cmp !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    chk("no hold", vld, 0);
    chk("no value", vo, 0);
    stop_run();
  endtask : t_no_hold
  task automatic final_report;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial
  begin
    #100000;
    n_mismatch++;
    final_report();
  end
  initial
  begin
    repeat (2) @(negedge clk);
    nrst = 1;
    t_settings();
    t_empty();
    stwr = 1;
    for (int i = 0; i < 4; i++)
    begin
      sadr = i[9:0]; sval = 24'h000011 * (i + 1); sttrig = (i == 0);
      @(negedge clk);
    end
    stwr = 0;
    ns = 11'h004;
    t_run();
    t_pause();
    t_no_hold();
    final_report();
  end
endmodule : load_step_sequencer_tb
bind load_step_sequencer load_step_sequencer_asserts load_step_sequencer_asserts_inst (
  .CLK_IN, .NRST_IN, .SEQ_ENABLE_IN, .LOAD_ON_IN, .CONTINUE_IN, .SET_WR_IN, .MODE_IN,
  .NUM_STEPS_IN, .SET_VALUE_OUT, .SET_VALID_OUT, .step_trigger_output, .SEQ_IND_OUT,
  .SEQ_IND_ACTIVE_OUT, .RUNNING_OUT, .PAUSED_OUT, .EMPTY_OUT, .SETTING_ERR_OUT);
`default_nettype wire
